// ===== ias_cfg.svh
// constants for the interrupt activation steering block
// assumes a 32-bit axi4-lite slave at byte addresses, 50 MHz system clock
`ifndef IAS_CFG_SVH
`define IAS_CFG_SVH

// *********************************************************
// register byte offsets
// *********************************************************
`define IAS_OFF_ENA_A     20'hfff20
`define IAS_OFF_ENA_B     20'hfff22
`define IAS_OFF_ENA_C     20'hfff24
`define IAS_OFF_ENA_D     20'hfff26
`define IAS_OFF_ENA_E     20'hfff28
`define IAS_OFF_XFER_CTL  20'hfff30
`define IAS_OFF_MODE_B    20'hfff34
`define IAS_OFF_DMA_SEL   20'hfff38
`define IAS_OFF_DMA_MODE  20'hfff3c
`define IAS_OFF_IRQ_STAT  20'hfff40
`define IAS_OFF_IRQ_MASK  20'hfff44
`define IAS_OFF_ROUTE     20'hfff48

// *********************************************************
// field positions and masks
// *********************************************************
`define IAS_ENA_E_MASK    16'h3000
`define IAS_XCTL_MASK     8'h19
`define IAS_DMODE_TFHI    3
`define IAS_DMODE_TFLO    2
`define IAS_DMODE_TEN     1
`define IAS_DMODE_CLAIM   0

// *********************************************************
// reset values and access timing
// *********************************************************
`define IAS_RST_ENA       16'h0000
`define IAS_RST_XCTL      8'h00
`define IAS_RD_CYC        2
`define IAS_WR_CYC        3

`endif

// ===== ias_far_end.sv
// far side model: the peripherals raising request levels
// assumes the bench hands it the wanted pattern
`timescale 1ns/1ps
module ias_far_end (
   input  wire logic        CLK_SYS,
   input  wire logic        NRST,
   input  wire logic [79:0] PAT,
   output logic [79:0]      IRQ_SRC
);
   // requests are levels, quiet while in reset
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) IRQ_SRC <= 80'h0;
      else IRQ_SRC <= PAT;
   end
endmodule

// ===== ias_pkg.sv
// types for the interrupt activation steering block
// assumes ias_cfg.svh is compiled alongside
package ias_pkg;

   // bus slave phases
   typedef enum logic [1:0] {
      IAS_IDLE  = 2'b00,
      IAS_RWAIT = 2'b01,
      IAS_WWAIT = 2'b10,
      IAS_RESP  = 2'b11
   } ias_phase_type;

   // whole state of the top module
   typedef struct packed {
      ias_phase_type phase;
      logic [1:0]    cnt;
      logic          is_wr;
      logic [19:0]   addr;
      logic [31:0]   wdata;
      logic [3:0]    wstrb;
      logic          aw_got;
      logic          w_got;
      logic [79:0]   ena;
      logic [7:0]    xctl;
      logic [79:0]   sel_b;
      logic [27:0]   dma_sel;
      logic [15:0]   dma_mode;
      logic [79:0]   stat;
      logic [79:0]   mask;
      logic [79:0]   to_dma_ctl;
      logic [79:0]   to_xfer;
      logic [79:0]   to_cpu;
      logic [79:0]   auto_clr;
      logic [3:0]    dma_req;
      logic          awready;
      logic          wready;
      logic          bvalid;
      logic          arready;
      logic          rvalid;
      logic [31:0]   rdata;
      logic [1:0]    resp;
      logic          irq;
   } ias_state_type;

endpackage

// ===== ias_steer.sv
// interrupt activation steering: dma claim, transfer start or cpu interrupt
// assumes synchronous peripheral interrupt inputs and an axi4-lite master
`timescale 1ns/1ps
`include "ias_cfg.svh"

// Functional notes
// R1: channel source chosen by request-select register
// R2: claimed source withheld from transfer and cpu
// R3: unclaimed source routed by activation-enable bit
// R4: exactly five enable registers, A to E
// R5: claim, enable, interrupt-select set route and clear
// R6: enable E 16 bits, read 2, write 3
// R7: E and control initialised by reset
// R8: enable clear goes cpu, set goes transfer
module ias_steer #(
   parameter int NSRC  = 80,  // five registers of 16 sources
   parameter int NCH   = 4,   // dma channels
   parameter int SELW  = 7    // request-select width
) (
   input  wire logic        CLK_SYS,
   input  wire logic        NRST,
   input  wire logic [79:0] IRQ_SRC,
   output logic [79:0]      TO_XFER,
   output logic [79:0]      TO_CPU,
   output logic [79:0]      AUTO_CLR,
   output logic [3:0]       DMA_REQ,
   output logic             IRQ,
   input  wire logic [19:0] S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [19:0] S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY
);

   // *********************************************************
   // state
   // *********************************************************
   ias_pkg::ias_state_type s_q;   // registered state
   ias_pkg::ias_state_type s_d;   // next state
   logic [79:0]            claim; // sources held by a dma channel

   // *********************************************************
   // claim decode
   // *********************************************************
   // a channel claims its source only in on-chip-interrupt transfer mode
   always_comb begin
      logic [3:0] m;
      logic [6:0] sel;
      m = 4'h0;
      sel = 7'h00;
      claim = '0;
      for (int c = 0; c < NCH; c++) begin
         m = s_q.dma_mode[c*4 +: 4];
         sel = s_q.dma_sel[c*SELW +: SELW];
         // R2: mode 1,0 with enable and claim
         if (m[`IAS_DMODE_TFHI] && !m[`IAS_DMODE_TFLO] && m[`IAS_DMODE_TEN]
             && m[`IAS_DMODE_CLAIM] && (int'(sel) < NSRC)) begin
            claim[sel] = 1'b1;
         end
      end
   end

   // *********************************************************
   // next state
   // *********************************************************
   always_comb begin
      logic [31:0] rd;
      logic [19:0] a;
      logic        hit;
      logic [4:0]  ri;
      logic [15:0] wv;
      logic [79:0] clr;
      rd = 32'h0;
      a = 20'h0;
      hit = 1'b0;
      ri = 5'h0;
      wv = 16'h0;
      clr = '0;
      s_d = s_q;

      // R1: per channel source selection
      // a select beyond the last source starts nothing instead of reading off the end
      for (int c = 0; c < NCH; c++) begin
         s_d.dma_req[c] = s_q.dma_mode[c*4 + `IAS_DMODE_TEN]
                          && (int'(s_q.dma_sel[c*SELW +: SELW]) < NSRC)
                          && IRQ_SRC[s_q.dma_sel[c*SELW +: SELW]];
      end
      for (int i = 0; i < NSRC; i++) begin
         // R2: claimed source goes only to dma
         s_d.to_dma_ctl[i] = claim[i];
         // R3: unclaimed routed by enable bit
         // R8: clear means cpu, set means transfer
         s_d.to_xfer[i] = IRQ_SRC[i] && !claim[i] && s_q.ena[i];
         s_d.to_cpu[i]  = IRQ_SRC[i] && !claim[i] && !s_q.ena[i];
         // R5: auto clear on claim, or on transfer start unless interrupt-select keeps request
         s_d.auto_clr[i] = IRQ_SRC[i] && (claim[i] || (s_q.ena[i] && !s_q.sel_b[i]));
      end
      // events: transfer starts latch sticky status; set beats clear
      s_d.irq = |(s_q.stat & s_q.mask);

      // axi slave handshake
      s_d.awready = 1'b0;
      s_d.wready = 1'b0;
      s_d.arready = 1'b0;
      case (s_q.phase)
         ias_pkg::IAS_IDLE: begin
            // reads first when both arrive together
            if (S_AXI_ARVALID && !s_q.aw_got && !s_q.w_got) begin
               s_d.arready = 1'b1;
               s_d.addr = S_AXI_ARADDR;
               s_d.is_wr = 1'b0;
               s_d.cnt = 2'(`IAS_RD_CYC - 1);
               s_d.phase = ias_pkg::IAS_RWAIT;
            end else begin
               if (S_AXI_AWVALID && !s_q.aw_got && !s_q.awready) begin
                  s_d.awready = 1'b1;
                  s_d.aw_got = 1'b1;
                  s_d.addr = S_AXI_AWADDR;
               end
               if (S_AXI_WVALID && !s_q.w_got && !s_q.wready) begin
                  s_d.wready = 1'b1;
                  s_d.w_got = 1'b1;
                  s_d.wdata = S_AXI_WDATA;
                  s_d.wstrb = S_AXI_WSTRB;
               end
               if (s_q.aw_got && s_q.w_got) begin
                  s_d.is_wr = 1'b1;
                  // R6: write takes three clocks
                  s_d.cnt = 2'(`IAS_WR_CYC - 1);
                  s_d.phase = ias_pkg::IAS_WWAIT;
               end
            end
         end
         ias_pkg::IAS_RWAIT, ias_pkg::IAS_WWAIT: begin
            if (s_q.cnt != 2'h0) begin
               s_d.cnt = s_q.cnt - 2'h1;
            end else begin
               a = {s_q.addr[19:2], 2'b00};
               hit = 1'b1;
               ri = 5'h0;
               // R4: only five enable registers decode
               case (a)
                  `IAS_OFF_ENA_A:    ri = 5'd0;
                  `IAS_OFF_ENA_C:    ri = 5'd2;
                  `IAS_OFF_ENA_E:    ri = 5'd4;
                  `IAS_OFF_XFER_CTL: ri = 5'd5;
                  `IAS_OFF_MODE_B:   ri = 5'd6;
                  `IAS_OFF_DMA_SEL:  ri = 5'd7;
                  `IAS_OFF_DMA_MODE: ri = 5'd8;
                  `IAS_OFF_IRQ_STAT: ri = 5'd9;
                  `IAS_OFF_IRQ_MASK: ri = 5'd10;
                  default: hit = 1'b0;
               endcase
               // words at fff20/24 hold A|B and C|D; fff28 holds E in low half
               case (ri)
                  5'd0: rd = s_q.ena[31:0];
                  5'd2: rd = s_q.ena[63:32];
                  // R6: enable E is a 16-bit register
                  5'd4: rd = {16'h0, s_q.ena[79:64] & `IAS_ENA_E_MASK};
                  5'd5: rd = {24'h0, s_q.xctl};
                  5'd6: rd = s_q.sel_b[31:0];
                  5'd7: rd = {4'h0, s_q.dma_sel};
                  5'd8: rd = {16'h0, s_q.dma_mode};
                  5'd9: rd = {16'h0, s_q.stat[79:64]} | {16'h0, s_q.stat[15:0]};
                  5'd10: rd = {16'h0, s_q.mask[15:0]};
                  default: rd = 32'h0;
               endcase
               if (s_q.is_wr && hit) begin
                  for (int b = 0; b < 4; b++) begin
                     if (s_q.wstrb[b]) begin
                        case (ri)
                           5'd0: s_d.ena[b*8 +: 8] = s_q.wdata[b*8 +: 8];
                           5'd2: s_d.ena[32 + b*8 +: 8] = s_q.wdata[b*8 +: 8];
                           5'd6: s_d.sel_b[b*8 +: 8] = s_q.wdata[b*8 +: 8];
                           5'd7: s_d.dma_sel[b*7 +: 7] = s_q.wdata[b*8 +: 7];
                           5'd8: if (b < 2) s_d.dma_mode[(b & 1)*8 +: 8] = s_q.wdata[b*8 +: 8];
                           5'd10: if (b < 2) s_d.mask[b*8 +: 8] = s_q.wdata[b*8 +: 8];
                           default: ;
                        endcase
                     end
                  end
                  if (ri == 5'd4 && |s_q.wstrb[1:0]) begin
                     wv = s_q.wdata[15:0] & `IAS_ENA_E_MASK;
                     s_d.ena[79:64] = wv;
                  end
                  if (ri == 5'd5 && s_q.wstrb[0]) begin
                     s_d.xctl = s_q.wdata[7:0] & `IAS_XCTL_MASK;
                  end
               end
               // status read clears what was shown
               if (!s_q.is_wr && ri == 5'd9) begin
                  clr[15:0] = s_q.stat[15:0] | s_q.stat[79:64];
               end
               s_d.rdata = rd;
               s_d.resp = hit ? 2'b00 : 2'b10;
               s_d.bvalid = s_q.is_wr;
               s_d.rvalid = !s_q.is_wr;
               s_d.aw_got = 1'b0;
               s_d.w_got = 1'b0;
               s_d.phase = ias_pkg::IAS_RESP;
            end
         end
         ias_pkg::IAS_RESP: begin
            if ((s_q.bvalid && S_AXI_BREADY) || (s_q.rvalid && S_AXI_RREADY)) begin
               s_d.bvalid = 1'b0;
               s_d.rvalid = 1'b0;
               s_d.phase = ias_pkg::IAS_IDLE;
            end
         end
         default: s_d.phase = ias_pkg::IAS_IDLE;
      endcase
      // sticky: a transfer start in the clearing cycle stays set
      clr[79:64] = clr[15:0];
      s_d.stat = (s_q.stat & ~clr) | s_d.to_xfer;
   end

   // *********************************************************
   // registers
   // *********************************************************
   // R7: enable and control cleared by reset
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs are flip-flop copies
   assign TO_XFER       = s_q.to_xfer;
   assign TO_CPU        = s_q.to_cpu;
   assign AUTO_CLR      = s_q.auto_clr;
   assign DMA_REQ       = s_q.dma_req;
   assign IRQ           = s_q.irq;
   assign S_AXI_AWREADY = s_q.awready;
   assign S_AXI_WREADY  = s_q.wready;
   assign S_AXI_BRESP   = s_q.resp;
   assign S_AXI_BVALID  = s_q.bvalid;
   assign S_AXI_ARREADY = s_q.arready;
   assign S_AXI_RDATA   = s_q.rdata;
   assign S_AXI_RRESP   = s_q.resp;
   assign S_AXI_RVALID  = s_q.rvalid;

endmodule

// ===== ias_steer_sva.sv
// checker: port relations of the steering block
// assumes it is bound to every ias_steer instance
`timescale 1ns/1ps
module ias_steer_sva (
   input wire logic        CLK_SYS,
   input wire logic        NRST,
   input wire logic [79:0] IRQ_SRC,
   input wire logic [79:0] TO_XFER,
   input wire logic [79:0] TO_CPU,
   input wire logic [3:0]  DMA_REQ,
   input wire logic        IRQ,
   input wire logic        S_AXI_AWREADY,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [1:0]  S_AXI_RRESP,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY
);
   // ****************************************
   // one clock domain, reset disables all
   // ****************************************
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);
   rd_answer_a: assert property (
      S_AXI_ARVALID && S_AXI_ARREADY |-> ##[1:4] S_AXI_RVALID) else $error("read not answered");
   rd_hold_a: assert property (
      S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read answer dropped");
   aw_pulse_a: assert property (
      S_AXI_AWREADY |=> !S_AXI_AWREADY) else $error("awready longer than one cycle");
   one_route_a: assert property (
      (TO_XFER & TO_CPU) == 80'h0) else $error("source sent two ways");
   // a start needs a live source within two cycles
   xfer_src_a: assert property (
      (TO_XFER & ~($past(IRQ_SRC) | $past(IRQ_SRC, 2))) == 80'h0) else $error("start without source");
   dma_src_a: assert property (
      DMA_REQ != 4'h0 |-> ($past(IRQ_SRC) | $past(IRQ_SRC, 2)) != 80'h0) else $error("dma without source");
   slverr_a: assert property (
      S_AXI_RVALID && S_AXI_RRESP == 2'b10 |-> S_AXI_RDATA == 32'h0) else $error("refused read has data");
   rst_zero_a: assert property (
      $rose(NRST) |-> TO_XFER == 80'h0 && TO_CPU == 80'h0 && !IRQ) else $error("outputs live at reset");
endmodule

bind ias_steer ias_steer_sva chk_u (.*);

// ===== ias_tb.sv
// testbench: axi4-lite master, request pattern, output scoreboard
// assumes ias_cfg.svh on the include path
`timescale 1ns/1ps
`include "ias_cfg.svh"
module testbench;
   logic        CLK_SYS = 0, NRST = 0, chk = 0;
   logic        S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
   logic        S_AXI_ARVALID = 0, S_AXI_RREADY = 0, IRQ, S_AXI_AWREADY;
   logic        S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   logic [19:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
   logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA;
   logic [3:0]  S_AXI_WSTRB = 4'hf, DMA_REQ, dmode = 0;
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
   logic [79:0] PAT = 0, IRQ_SRC, TO_XFER, TO_CPU, AUTO_CLR, ena = 0;
   logic [31:0] selb = 0;
   logic [6:0]  dsel = 0;
   logic [244:0] rq[$], oq[$];             // expected answers, oldest first
   int          seed = 78550, num_errors = 0, samples_checked = 0;

   ias_steer   dut_u (.*);
   ias_far_end far_u (.*);

   initial forever #10 CLK_SYS = ~CLK_SYS;

   task automatic cmp(input logic [244:0] s, input logic [244:0] e);
      samples_checked++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic end_of_test();
      if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // ****************************************
   // bus cycles, bounded waits
   // ****************************************
   task automatic wr(input logic [19:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      rq.push_back(245'({r, 32'h0}));
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1;
      S_AXI_WVALID <= 1;
      S_AXI_BREADY <= 1;
      for (n = 0; n < 40; n++) begin
         @(posedge CLK_SYS);
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 0;
         if (S_AXI_BVALID) break;
      end
      S_AXI_BREADY <= 0;
      if (n == 40) begin
         num_errors++;
         end_of_test();
      end
      @(posedge CLK_SYS);
   endtask

   // rready offered with the address and held until the answer is sampled
   task automatic rd(input logic [19:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      rq.push_back(245'({r, d}));
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1;
      S_AXI_RREADY <= 1;
      for (n = 0; n < 40; n++) begin
         @(posedge CLK_SYS);
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 0;
         if (S_AXI_RVALID) break;
      end
      S_AXI_RREADY <= 0;
      if (n == 40) begin
         num_errors++;
         end_of_test();
      end
      @(posedge CLK_SYS);
   endtask

   // expected routing from the bench's own register copy
   task automatic look(input logic ie);
      logic [79:0] cl;
      repeat (6) @(posedge CLK_SYS);
      cl = (dmode == 4'hb) ? 80'h1 << dsel : 80'h0;
      oq.push_back({ie, 3'b0, dmode[1] & PAT[dsel], PAT & ena & ~cl, PAT & ~ena & ~cl,
                    PAT & (cl | (ena & ~{48'h0, selb}))});
      chk <= 1;
      @(posedge CLK_SYS);
      chk <= 0;
   endtask

   // scoreboard: takes the oldest note whenever an answer shows
   always @(posedge CLK_SYS) begin
      if (S_AXI_RVALID && S_AXI_RREADY) cmp(245'({S_AXI_RRESP, S_AXI_RDATA}), rq.pop_front());
      if (S_AXI_BVALID && S_AXI_BREADY) cmp(245'({S_AXI_BRESP, 32'h0}), rq.pop_front());
      if (chk) cmp({IRQ, DMA_REQ, TO_XFER, TO_CPU & PAT, AUTO_CLR & PAT}, oq.pop_front());
   end

   initial begin
      logic [31:0] d;
      repeat (10) @(posedge CLK_SYS);
      NRST <= 1;
      @(posedge CLK_SYS);
      rd(`IAS_OFF_ENA_E, 32'h0, 2'b00);
      rd(`IAS_OFF_XFER_CTL, 32'h0, 2'b00);
      wr(`IAS_OFF_ENA_E, 32'hffff, 2'b00);
      rd(`IAS_OFF_ENA_E, 32'h3000, 2'b00);
      wr(`IAS_OFF_XFER_CTL, 32'hff, 2'b00);
      rd(`IAS_OFF_XFER_CTL, 32'h19, 2'b00);
      ena[79:64] = 16'h3000;
      rd(20'hff000, 32'h0, 2'b10);
      rd(20'hfff2c, 32'h0, 2'b10);
      wr(20'hff000, 32'h1, 2'b10);
      // interrupt raised, cleared by read, masked
      wr(`IAS_OFF_IRQ_MASK, 32'h1, 2'b00);
      wr(`IAS_OFF_ENA_A, 32'h21, 2'b00);
      ena[15:0] = 16'h21;
      PAT <= 80'h1;
      look(1);
      PAT <= 80'h0;
      look(1);
      rd(`IAS_OFF_IRQ_STAT, 32'h1, 2'b00);
      look(0);
      wr(`IAS_OFF_IRQ_MASK, 32'h0, 2'b00);
      // every mode of channel 0 on source 5
      wr(`IAS_OFF_DMA_SEL, 32'h5, 2'b00);
      dsel = 7'h5;
      PAT <= 80'h20;
      for (int m = 0; m < 16; m++) begin
         wr(`IAS_OFF_DMA_MODE, 32'(m), 2'b00);
         dmode = 4'(m);
         look(0);
      end
      // interrupt select stops the auto clear
      wr(`IAS_OFF_MODE_B, 32'h20, 2'b00);
      selb = 32'h20;
      look(0);
      // random enables over A to D and sources over A to E
      repeat (6) begin
         d = $random(seed);
         wr(`IAS_OFF_ENA_A, d, 2'b00);
         ena[31:0] = d;
         d = $random(seed);
         wr(`IAS_OFF_ENA_C, d, 2'b00);
         ena[63:32] = d;
         PAT <= {16'($random(seed)), 32'($random(seed)), 32'($random(seed))};
         look(0);
      end
      // a reset mid-run brings E and control back to zero
      NRST <= 0;
      repeat (3) @(posedge CLK_SYS);
      NRST <= 1;
      @(posedge CLK_SYS);
      rd(`IAS_OFF_ENA_E, 32'h0, 2'b00);
      rd(`IAS_OFF_XFER_CTL, 32'h0, 2'b00);
      end_of_test();
   end
endmodule
